// [rtl/tef_cond.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tef_regs.svh"
// ----------------------------------------
// input conditioning: polarity, filter,
// edge detect and prescale, in one of two
// orders
// ----------------------------------------
module tef_cond #(
    parameter bit EDGE_FIRST = 1'b0,
    parameter int FILT_LEN = `TEF_FILT_LEN
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sig_in,
    input wire logic invert,
    input wire logic [1:0] psc,
    output logic pulse,
    output logic level
);
    import tef_pkg::*;
    localparam logic [3:0] FTOP = 4'(FILT_LEN - 1);
    tef_cond_st_t s, n;
    logic pol, x, edge_hit, evt;
    logic [2:0] ptop;

    always_comb
    begin
        n = s;
        pol = sig_in ^ invert;
        ptop = (3'h1 << psc) - 3'h1;
        edge_hit = 1'b0;
        evt = 1'b0;
        // edge-first path filters the prescaled toggle
        x = EDGE_FIRST ? s.tog : pol;
        if (EDGE_FIRST)
            edge_hit = pol & ~s.prev;
        if (x == s.lvl)
            n.fcnt = 4'h0;
        else if (s.fcnt >= FTOP)
        begin
            n.lvl = x;
            n.fcnt = 4'h0;
        end
        else
            n.fcnt = s.fcnt + 4'h1;
        if (!EDGE_FIRST)
            edge_hit = n.lvl & ~s.lvl;
        if (edge_hit)
        begin
            if (s.pcnt >= ptop)
            begin
                n.pcnt = 3'h0;
                evt = 1'b1;
            end
            else
                n.pcnt = s.pcnt + 3'h1;
        end
        if (EDGE_FIRST)
        begin
            n.tog = s.tog ^ evt;
            n.pulse = n.lvl ^ s.lvl;
        end
        else
            n.pulse = evt;
        n.prev = pol;
    end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            s <= '0;
        else
            s <= n;

    assign pulse = s.pulse;
    assign level = s.lvl;
endmodule : tef_cond
`default_nettype wire

// [rtl/tef_pkg.sv]
package tef_pkg;
`include "tef_regs.svh"
    // ----------------------------------------
    // bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tef_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tef_apb_rsp_t;
    // ----------------------------------------
    // per timer carriers
    // ----------------------------------------
    typedef struct packed {
        logic update_event;
        logic [`TEF_NCH-1:0] compare_match;
        logic [`TEF_NCH-1:0] compare_reference;
        logic [`TEF_CW-1:0] counter_value;
        logic master_trigger_output;
        logic external_clock_pin;
        logic external_clock_mask;
        logic [`TEF_NCH-1:0] channel_pin_in;
    } tef_tmr_in_t;
    typedef struct packed {
        logic [7:0] control_one;
        logic count_down;
        logic gated_mode;
        logic slave_trigger_input;
        logic external_trigger_in;
        logic external_trigger_conditioned;
        logic [`TEF_NCH-1:0] channel_capture_prescaled;
        logic [`TEF_NCH-1:0] channel_pin_signal;
        logic [`TEF_NCH-1:0][`TEF_CW-1:0] compare_value;
        logic irq;
    } tef_tmr_out_t;
    // ----------------------------------------
    // state records
    // ----------------------------------------
    typedef struct packed {
        logic prev;
        logic [3:0] fcnt;
        logic lvl;
        logic [2:0] pcnt;
        logic tog;
        logic pulse;
    } tef_cond_st_t;
    typedef struct packed {
        tef_apb_rsp_t apb;
        logic [1:0][7:0] ctrl1;
        logic [1:0][31:0] cfg;
        logic [1:0][`TEF_FW-1:0] flag;
        logic [1:0][`TEF_FW-1:0] mask;
        logic [1:0][`TEF_NCH-1:0] miss;
        logic [1:0][`TEF_NCH-1:0][`TEF_CW-1:0] ccr;
        logic [1:0] gen_en;
        logic [1:0] sys_stat;
        logic [1:0] sys_mask;
        logic [1:0] trig_prev;
        tef_tmr_out_t [1:0] out;
        logic irq_summary;
    } tef_top_st_t;
endpackage : tef_pkg

// [rtl/tef_regs.svh]
`ifndef TEF_REGS_SVH
`define TEF_REGS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define TEF_NCH 4
`define TEF_CW 16
`define TEF_FW 6
`define TEF_FILT_LEN 4
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TEF_TMR_STRIDE 8'h40
`define TEF_CTRL1 8'h00
`define TEF_CFG 8'h04
`define TEF_FLAG 8'h08
`define TEF_MASK 8'h0c
`define TEF_MISS 8'h10
`define TEF_CCR0 8'h20
`define TEF_GEN_SET 8'h80
`define TEF_GEN_CLR 8'h84
`define TEF_SYS_STAT 8'h88
`define TEF_SYS_MASK 8'h8c
// ----------------------------------------
// fields
// ----------------------------------------
`define TEF_CEN 0
`define TEF_OPM 3
`define TEF_DIR 4
`define TEF_CMS 5
`define TEF_FLG_UPD 0
`define TEF_FLG_CH0 1
`define TEF_FLG_TRIG 5
`define TEF_CFG_GATED 0
`define TEF_CFG_EPOL 1
`define TEF_CFG_EPSC 2
`define TEF_CFG_TSRC 4
`define TEF_CFG_MSKEN 5
`define TEF_CFG_CAP 8
`define TEF_CFG_IPOL 12
`define TEF_CFG_OPOL 16
`define TEF_CFG_CPSC 20
`define TEF_RST_VAL 32'h0000_0000
`endif

// [rtl/tef_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tef_regs.svh"
// How it works
// - per-timer irq line, gated by global set/clear enable bits
// - trigger flag on trigger rising edge, either edge when gated
// - per-channel event flags plus an update flag
// - event flags clear on written ones; zeros keep them
// - reading a capture channel's value clears its flag
// - only flags with mask bit one raise the timer irq
// - channel event while its flag is set marks it missed
// - missed bits clear on written ones; zeros keep them
// - each timer's trigger is the other's master trigger, or its own filtered channel 0 level when selected
// - compare pin equals the high-active reference, maybe inverted
// - filters and conditioning all run on the peripheral clock
// - enabled clock mask is anded with the other timer's clock
// - external trigger: polarity, edge, prescale, then filter
// - channel input filtered, edge detected, prescaled, then captured
// - control one holds fields in bits 7..0, upper bits zero
// - single pulse mode clears counter enable at update
// - direction one counts down, only in edge aligned mode
module tef_top #(
    parameter int FILT_LEN = `TEF_FILT_LEN
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire tef_pkg::tef_apb_req_t apb_req,
    output var tef_pkg::tef_apb_rsp_t apb_rsp,
    input wire tef_pkg::tef_tmr_in_t [1:0] tmr_in,
    output var tef_pkg::tef_tmr_out_t [1:0] tmr_out,
    output logic irq_summary
);
    import tef_pkg::*;
    localparam int NCH = `TEF_NCH;
    localparam int FW = `TEF_FW;

    // ----------------------------------------
    // decode helper
    // ----------------------------------------
    function automatic logic off_is(
        input logic [7:0] a,
        input int t,
        input logic [7:0] off
    );
        logic [7:0] base;
        base = 8'(t) * `TEF_TMR_STRIDE;
        return a == (base + off);
    endfunction : off_is

    tef_top_st_t s, n;
    logic setup, acc, wr, rd, hit;
    logic [1:0][FW-1:0] fset, fclr, fkeep, fgone;
    logic [1:0][NCH-1:0] mset, mclr, mkeep, ce;
    logic [1:0][NCH-1:0] cap_pulse, ch_lvl;
    logic [1:0] ext_trig_pulse, ext_trig_in, trig_sel, req, ctl_wr;

    // ----------------------------------------
    // conditioning chains
    // ----------------------------------------
    // all conditioning is clocked by pclk
    for (genvar t = 0; t < 2; t++)
    begin : g_tmr
        // other timer's mask gates this clock pin
        assign ext_trig_in[t] = tmr_in[t].external_clock_pin &
            (~s.cfg[1-t][`TEF_CFG_MSKEN] |
             tmr_in[1-t].external_clock_mask);
        // polarity, edge, prescale, filter
        tef_cond #(.EDGE_FIRST(1'b1), .FILT_LEN(FILT_LEN)) u_ext_trig (
            .pclk(pclk),
            .presetn(presetn),
            .sig_in(ext_trig_in[t]),
            .invert(s.cfg[t][`TEF_CFG_EPOL]),
            .psc(s.cfg[t][`TEF_CFG_EPSC +: 2]),
            .pulse(ext_trig_pulse[t]),
            .level()
        );
        for (genvar c = 0; c < NCH; c++)
        begin : g_ch
            // filter, edge, prescale into capture
            tef_cond #(.EDGE_FIRST(1'b0), .FILT_LEN(FILT_LEN)) u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .sig_in(tmr_in[t].channel_pin_in[c]),
                .invert(s.cfg[t][`TEF_CFG_IPOL + c]),
                .psc(s.cfg[t][`TEF_CFG_CPSC +: 2]),
                .pulse(cap_pulse[t][c]),
                .level(ch_lvl[t][c])
            );
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        setup = apb_req.psel & ~apb_req.penable;
        acc = apb_req.psel & apb_req.penable & s.apb.pready;
        wr = acc & apb_req.pwrite;
        rd = acc & ~apb_req.pwrite;
        hit = 1'b0;
        fset = '0;
        fclr = '0;
        mset = '0;
        mclr = '0;
        ce = '0;
        trig_sel = '0;
        ctl_wr = '0;
        n.apb.pready = setup;
        n.apb.prdata = 32'h0;
        n.apb.pslverr = 1'b0;
        for (int t = 0; t < 2; t++)
        begin
            // trigger from the other timer, or own channel 0 level
            trig_sel[t] = s.cfg[t][`TEF_CFG_TSRC] ? ch_lvl[t][0] :
                tmr_in[1-t].master_trigger_output;
            if (s.cfg[t][`TEF_CFG_GATED])
                fset[t][`TEF_FLG_TRIG] =
                    trig_sel[t] ^ s.trig_prev[t];
            else
                fset[t][`TEF_FLG_TRIG] =
                    trig_sel[t] & ~s.trig_prev[t];
            n.trig_prev[t] = trig_sel[t];
            fset[t][`TEF_FLG_UPD] = tmr_in[t].update_event;
            for (int c = 0; c < NCH; c++)
            begin
                // capture or compare event per channel
                ce[t][c] = s.cfg[t][`TEF_CFG_CAP + c] ?
                    cap_pulse[t][c] : tmr_in[t].compare_match[c];
                fset[t][`TEF_FLG_CH0 + c] = ce[t][c];
                if (s.cfg[t][`TEF_CFG_CAP + c] &&
                    rd && off_is(apb_req.paddr, t,
                    `TEF_CCR0 + 8'(4 * c)))
                    fclr[t][`TEF_FLG_CH0 + c] = 1'b1;
                if (s.cfg[t][`TEF_CFG_CAP + c] && cap_pulse[t][c])
                    n.ccr[t][c] = tmr_in[t].counter_value;
                else if (wr && off_is(apb_req.paddr, t,
                    `TEF_CCR0 + 8'(4 * c)))
                    n.ccr[t][c] = apb_req.pwdata[`TEF_CW-1:0];
            end
            // missed while flag still up
            mset[t] = ce[t] & s.flag[t][`TEF_FLG_CH0 +: NCH];
            if (wr && off_is(apb_req.paddr, t, `TEF_FLAG))
                fclr[t] = fclr[t] | apb_req.pwdata[FW-1:0];
            if (wr && off_is(apb_req.paddr, t, `TEF_MISS))
                mclr[t] = apb_req.pwdata[`TEF_FLG_CH0 +: NCH];
            // set beats clear
            n.flag[t] = (s.flag[t] & ~fclr[t]) | fset[t];
            n.miss[t] = (s.miss[t] & ~mclr[t]) | mset[t];
            if (wr && off_is(apb_req.paddr, t, `TEF_CFG))
                n.cfg[t] = apb_req.pwdata;
            if (wr && off_is(apb_req.paddr, t, `TEF_MASK))
                n.mask[t] = apb_req.pwdata[FW-1:0];
            ctl_wr[t] = wr && off_is(apb_req.paddr, t, `TEF_CTRL1);
            if (ctl_wr[t])
                n.ctrl1[t] = apb_req.pwdata[7:0];
            else if (s.ctrl1[t][`TEF_OPM] && tmr_in[t].update_event)
                n.ctrl1[t][`TEF_CEN] = 1'b0;
            // global enable set and clear
            if (wr && off_is(apb_req.paddr, 0, `TEF_GEN_SET) &&
                apb_req.pwdata[t])
                n.gen_en[t] = 1'b1;
            else if (wr && off_is(apb_req.paddr, 0, `TEF_GEN_CLR) &&
                apb_req.pwdata[t])
                n.gen_en[t] = 1'b0;
            // timer irq: enabled line, masked flags
            req[t] = s.gen_en[t] & (|(s.flag[t] & s.mask[t]));
            n.out[t].irq = req[t];
            n.out[t].control_one = s.ctrl1[t];
            // down only when edge aligned
            n.out[t].count_down = s.ctrl1[t][`TEF_DIR] &
                (s.ctrl1[t][`TEF_CMS +: 2] == 2'h0);
            n.out[t].gated_mode = s.cfg[t][`TEF_CFG_GATED];
            n.out[t].slave_trigger_input = trig_sel[t];
            n.out[t].external_trigger_in = ext_trig_in[t];
            n.out[t].external_trigger_conditioned = ext_trig_pulse[t];
            n.out[t].channel_capture_prescaled = cap_pulse[t];
            // reference xor channel polarity
            n.out[t].channel_pin_signal =
                tmr_in[t].compare_reference ^
                s.cfg[t][`TEF_CFG_OPOL +: NCH];
            n.out[t].compare_value = s.ccr[t];
        end
        // sticky summary: set wins over read clear
        if (rd && off_is(apb_req.paddr, 0, `TEF_SYS_STAT))
            n.sys_stat = 2'h0;
        n.sys_stat = n.sys_stat | {(|mset[1]), (|mset[0])};
        if (wr && off_is(apb_req.paddr, 0, `TEF_SYS_MASK))
            n.sys_mask = apb_req.pwdata[1:0];
        n.irq_summary = |(s.sys_stat & s.sys_mask);

        // ----------------------------------------
        // read mux, built in the setup cycle
        // ----------------------------------------
        // data sampled one cycle before the access edge
        for (int t = 0; t < 2; t++)
        begin
            if (off_is(apb_req.paddr, t, `TEF_CTRL1))
            begin
                hit = 1'b1;
                n.apb.prdata = {24'h0, s.ctrl1[t]};
            end
            else if (off_is(apb_req.paddr, t, `TEF_CFG))
            begin
                hit = 1'b1;
                n.apb.prdata = s.cfg[t];
            end
            else if (off_is(apb_req.paddr, t, `TEF_FLAG))
            begin
                hit = 1'b1;
                n.apb.prdata = 32'(s.flag[t]);
            end
            else if (off_is(apb_req.paddr, t, `TEF_MASK))
            begin
                hit = 1'b1;
                n.apb.prdata = 32'(s.mask[t]);
            end
            else if (off_is(apb_req.paddr, t, `TEF_MISS))
            begin
                hit = 1'b1;
                n.apb.prdata = 32'({s.miss[t], 1'b0});
            end
            for (int c = 0; c < NCH; c++)
            begin
                if (off_is(apb_req.paddr, t, `TEF_CCR0 + 8'(4 * c)))
                begin
                    hit = 1'b1;
                    n.apb.prdata = 32'(s.ccr[t][c]);
                end
            end
        end
        if (off_is(apb_req.paddr, 0, `TEF_GEN_SET) ||
            off_is(apb_req.paddr, 0, `TEF_GEN_CLR))
        begin
            hit = 1'b1;
            n.apb.prdata = 32'(s.gen_en);
        end
        else if (off_is(apb_req.paddr, 0, `TEF_SYS_STAT))
        begin
            hit = 1'b1;
            n.apb.prdata = 32'(s.sys_stat);
        end
        else if (off_is(apb_req.paddr, 0, `TEF_SYS_MASK))
        begin
            hit = 1'b1;
            n.apb.prdata = 32'(s.sys_mask);
        end
        // unmapped access: error, no side effect
        n.apb.pslverr = setup & ~hit;
        if (!setup)
            n.apb.prdata = 32'h0;
        fkeep = s.flag & ~fclr;
        fgone = s.flag & fclr & ~fset;
        mkeep = s.miss & ~mclr;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            s <= '0;
        else
            s <= n;

    assign apb_rsp = s.apb;
    assign tmr_out = s.out;
    assign irq_summary = s.irq_summary;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pready_next_a: assert property (
        (apb_req.psel && !apb_req.penable) |=> s.apb.pready)
        else $error("pready missing after setup");

    for (genvar t = 0; t < 2; t++)
    begin : g_chk
        sequence opm_hit;
            s.ctrl1[t][`TEF_OPM] && s.ctrl1[t][`TEF_CEN] &&
            tmr_in[t].update_event && !ctl_wr[t];
        endsequence
        sequence en_off;
            !s.ctrl1[t][`TEF_CEN] ##1 !s.out[t].control_one[`TEF_CEN];
        endsequence

        flag_set_wins_a: assert property (
            (|fset[t]) |=> ((s.flag[t] & $past(fset[t])) ==
            $past(fset[t])))
            else $error("flag set lost");

        flag_keep_a: assert property (
            1'b1 |=> ((s.flag[t] & $past(fkeep[t])) ==
            $past(fkeep[t])))
            else $error("flag dropped without clear");

        flag_clear_a: assert property (
            (|fgone[t]) |=> ((s.flag[t] & $past(fgone[t])) == '0))
            else $error("flag not cleared");

        irq_masked_a: assert property (
            ((s.flag[t] & s.mask[t]) == '0) [*2] |-> !s.out[t].irq)
            else $error("irq without masked flag");

        gen_enable_a: assert property (
            (wr && off_is(apb_req.paddr, 0, `TEF_GEN_SET) &&
            apb_req.pwdata[t]) |=> s.gen_en[t])
            else $error("global enable not set");

        gen_disable_a: assert property (
            (wr && off_is(apb_req.paddr, 0, `TEF_GEN_CLR) &&
            apb_req.pwdata[t] &&
            !off_is(apb_req.paddr, 0, `TEF_GEN_SET))
            |=> !s.gen_en[t] ##1 !s.out[t].irq)
            else $error("global enable not cleared");

        miss_set_a: assert property (
            (|mset[t]) |=> ((s.miss[t] & $past(mset[t])) ==
            $past(mset[t])))
            else $error("missed event not recorded");

        miss_keep_a: assert property (
            1'b1 |=> ((s.miss[t] & $past(mkeep[t])) ==
            $past(mkeep[t])))
            else $error("missed bit dropped");

        opm_stop_a: assert property (
            opm_hit |=> en_off)
            else $error("single pulse did not stop");
    end
endmodule : tef_top
`default_nettype wire

// [verif/tef_irq_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// top-level interrupt controller stand-in
// ----------------------------------------
module tef_irq_ctrl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] irq_line,
    input wire logic [1:0] ack,
    output logic [1:0] pending
);
    // latched so a one-cycle level is not lost before software acks it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending <= 2'h0;
        else
            pending <= (pending & ~ack) | irq_line;
    end
endmodule : tef_irq_ctrl_model
`default_nettype wire

// [verif/timer_event_flags_and_signals_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tef_regs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module timer_event_flags_and_signals_tb;
    import tef_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    tef_apb_req_t req = '0;
    tef_apb_rsp_t rsp;
    tef_tmr_in_t [1:0] ti = '0;
    tef_tmr_out_t [1:0] to;
    logic irq_summary;
    logic [1:0] ack = 2'h0;
    logic [1:0] pend;
    logic [31:0] rdata;
    logic rerr;
    int failures = 0;
    int checks_done = 0;
    always #5 pclk = ~pclk;
    // sticky catch of one-cycle pulses on the timer outputs
    logic [1:0] seen = 2'h0;
    always @(posedge pclk)
        seen <= seen | {to[0].channel_capture_prescaled[0],
            to[0].external_trigger_conditioned};
    // short filter keeps the capture path quick to reach
    tef_top #(.FILT_LEN(1)) uut (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(req),
        .apb_rsp(rsp),
        .tmr_in(ti),
        .tmr_out(to),
        .irq_summary(irq_summary)
    );
    tef_irq_ctrl_model ctl (
        .pclk(pclk),
        .presetn(presetn),
        .irq_line({to[1].irq, to[0].irq}),
        .ack(ack),
        .pending(pend)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task report_and_stop;
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // entered just after a rising edge; ends one idle cycle after access
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            report_and_stop;
        end
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // released lines must not keep looking valid
        req.paddr <= ~a;
        req.pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    task ev(input int t, input logic [3:0] cm, input logic u);
        ti[t].update_event <= u;
        ti[t].compare_match <= cm;
        @(posedge pclk);
        ti[t].update_event <= 1'b0;
        ti[t].compare_match <= 4'h0;
        @(posedge pclk);
    endtask : ev
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++)
        begin
            rd(8'(i * 4));
            `CHK(rdata, `TEF_RST_VAL);
        end
        rd(8'hfc);
        `CHK(rerr, 1'b1);
        `CHK(rdata, 32'h0000_0000);
        wr(`TEF_CTRL1, 32'hffff_ff76);
        rd(`TEF_CTRL1);
        `CHK(rdata, 32'h0000_0076);
        `CHK(to[0].control_one, 8'h76);
        `CHK(to[0].count_down, 1'b0);
        wr(`TEF_CTRL1, 32'h0000_0010);
        // timer outputs lag the register by one cycle
        @(posedge pclk);
        `CHK(to[0].count_down, 1'b1);
        wr(`TEF_CTRL1, 32'h0000_0009);
        ev(0, 4'h0, 1'b1);
        rd(`TEF_CTRL1);
        `CHK(rdata, 32'h0000_0008);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0001);
        wr(`TEF_GEN_SET, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        `CHK(to[0].irq, 1'b0);
        wr(`TEF_MASK, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        `CHK(to[0].irq, 1'b1);
        `CHK(pend[0], 1'b1);
        rd(`TEF_GEN_SET);
        `CHK(rdata[0], 1'b1);
        wr(`TEF_FLAG, 32'h0000_0000);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0001);
        wr(`TEF_GEN_CLR, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        `CHK(to[0].irq, 1'b0);
        ack <= 2'h1;
        @(posedge pclk);
        ack <= 2'h0;
        @(posedge pclk);
        `CHK(pend[0], 1'b0);
        wr(`TEF_FLAG, 32'h0000_0001);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0000);
        // second hit while set counts as missed
        wr(`TEF_SYS_MASK, 32'h0000_0001);
        ev(0, 4'h1, 1'b0);
        ev(0, 4'h1, 1'b0);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0002);
        rd(`TEF_MISS);
        `CHK(rdata, 32'h0000_0002);
        `CHK(irq_summary, 1'b1);
        rd(`TEF_SYS_STAT);
        `CHK(rdata, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK(irq_summary, 1'b0);
        wr(`TEF_MISS, 32'h0000_0000);
        rd(`TEF_MISS);
        `CHK(rdata, 32'h0000_0002);
        wr(`TEF_MISS, 32'h0000_0002);
        rd(`TEF_MISS);
        `CHK(rdata, 32'h0000_0000);
        ti[0].compare_reference <= 4'h5;
        wr(`TEF_CFG, 32'h0003_0000);
        @(posedge pclk);
        `CHK(to[0].channel_pin_signal, 4'h6);
        wr(`TEF_FLAG, 32'h0000_003f);
        ti[1].master_trigger_output <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(to[0].slave_trigger_input, 1'b1);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0020);
        wr(`TEF_FLAG, 32'h0000_0020);
        ti[1].master_trigger_output <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0000);
        wr(`TEF_CFG, 32'h0000_0001);
        ti[1].master_trigger_output <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(to[0].gated_mode, 1'b1);
        wr(`TEF_FLAG, 32'h0000_0020);
        ti[1].master_trigger_output <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0020);
        ti[1].external_clock_pin <= 1'b1;
        wr(`TEF_CFG, 32'h0000_0020);
        @(posedge pclk);
        `CHK(to[1].external_trigger_in, 1'b0);
        ti[0].external_clock_mask <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(to[1].external_trigger_in, 1'b1);
        wr(`TEF_FLAG, 32'h0000_003f);
        ti[0].counter_value <= 16'h1234;
        wr(`TEF_CFG, 32'h0000_0100);
        ti[0].channel_pin_in <= 4'h1;
        repeat (10) @(posedge pclk);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0002);
        rd(`TEF_CCR0);
        `CHK(rdata, 32'h0000_1234);
        rd(`TEF_FLAG);
        `CHK(rdata, 32'h0000_0000);
        `CHK(to[0].compare_value[0], 16'h1234);
        `CHK(seen[1], 1'b1);
        ti[0].external_clock_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(seen[0], 1'b1);
        report_and_stop;
    end
endmodule : timer_event_flags_and_signals_tb
`default_nettype wire
